//--- rtl/flash_regs.svh
// constants for the serial flash read and page copy core
// assumes a 100 MHz core clock; included by its bare name
`ifndef FLASH_REGS_SVH
`define FLASH_REGS_SVH

// command codes, shifted in msb first
`define OPC_RANDOM_READ 8'h03
`define OPC_COPY_BUF1 8'h53
`define OPC_COPY_BUF2 8'h55

// serial framing: opcode plus 24-bit address
`define LAST_CMD_BIT 6'h1F
`define CMD_CNT_ZERO 6'h00

// status byte: bit 7 is ready (1) or busy (0)
`define STATUS_READY_BIT 7
`define STATUS_RESET 8'h80
`define STATUS_BUSY 8'h00

// idle level of the serial data output
`define MISO_IDLE 1'b1

// longest page copy time and its cycle count
`define PAGE_COPY_TIME_US 400
`define CLK_MHZ 100
`define PAGE_COPY_CYCLES (`PAGE_COPY_TIME_US * `CLK_MHZ)

`endif

//--- rtl/flash_pkg.sv
// types shared by the serial flash core
// assumes nothing of its surroundings
package flash_pkg;

  // command decoder states on the serial link
  typedef enum logic [1:0] {ST_CMD, ST_STREAM, ST_DONE} link_state_type;

  // page copy engine states
  typedef enum logic {CP_IDLE, CP_RUN} copy_state_type;

  // synchronised pin levels
  typedef struct packed {
    logic chip_select_low;
    logic sclk;
    logic mosi;
  } pins_type;

  // a fully shifted page copy request, waiting for deselect
  typedef struct packed {
    logic valid;
    logic sel;
    logic [15:0] page;
  } copy_req_type;

endpackage

//--- rtl/byte_fifo.sv
// first-in first-out buffer with valid/ready on both sides
// assumes one clock and a synchronous active-low reset
`timescale 1ns/100ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  // depth must be a power of two for pointer wrap
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("byte_fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH]; // storage words
  logic [AW:0] wr_q, wr_d; // write pointer with lap bit
  logic [AW:0] rd_q, rd_d; // read pointer with lap bit
  logic push, pop;

  // full when laps differ and indices match
  assign in_ready = (wr_q ^ rd_q) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_q != rd_q;
  assign out_data = mem[rd_q[AW-1:0]];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // pointer next values
  always_comb begin
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
  end

  // pointer registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // storage write, no reset needed
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end
endmodule // byte_fifo

//--- rtl/flash_array.sv
// nonvolatile byte array with a registered read port
// assumes a preload write port driven by user logic on the same clock
`timescale 1ns/100ps
module flash_array #(
  parameter int AW = 12
) (
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [1 << AW]; // whole array, pages back to back

  // preload write and one-cycle read
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // flash_array

//--- rtl/in_system_flash_core.sv
// serial command handling of the in-system flash: random read and
// page copy into one of the sram page buffers
// assumes the serial pins come from another clock domain; the user
// side ports share ref_clk
`timescale 1ns/100ps
`include "flash_regs.svh"

// Behaviour
// [R1] master lowers select while clock high
// [R2] read opcode 03h, msb first
// [R3] 24-bit start address, any byte
// [R4] no dummy cycles, data on next fall
// [R5] one bit per fall, pointer auto-increments
// [R6] master ends read on falling edge
// [R7] select held low through whole command
// [R8] page crossing seamless, no extra cycles
// [R9] wrap from array end to start
// [R10] select rise stops read, output high
// [R11] random read leaves buffers untouched
// [R12] copy duplicates page, flash unchanged
// [R13] 53h loads buffer one, 55h two
// [R14] copy uses page number only
// [R15] copy starts on deselect, self-timed, bounded
// [R16] status bit 7 low while copying
// [R17] master polls ready or waits limit
// [R18] other buffer reads allowed while copying
// [R19] single-buffer variant lacks buffer two copy
// [R20] master clock at most 33 MHz
// [R21] short copy command discarded
module in_system_flash_core #(
  parameter int BYTE_BITS = 8,
  parameter int PAGE_BITS = 4,
  parameter int BUFFERS = 2,
  parameter int FIFO_DEPTH = 32,
  parameter int COPY_LIMIT_CYCLES = `PAGE_COPY_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic chip_select_low,
  input wire logic sclk,
  input wire logic mosi,
  output logic miso,
  output logic [7:0] status,
  input wire logic flash_wr_en,
  input wire logic [BYTE_BITS+PAGE_BITS-1:0] flash_wr_addr,
  input wire logic [7:0] flash_wr_data,
  input wire logic buf_rd_en,
  input wire logic buf_rd_sel,
  input wire logic [BYTE_BITS-1:0] buf_rd_addr,
  output logic [7:0] buf_rd_data
);
  import flash_pkg::*;

  localparam int AW = BYTE_BITS + PAGE_BITS;
  localparam int PAGE_BYTES = 1 << BYTE_BITS;

  // parameter sanity
  if (BUFFERS < 1 || BUFFERS > 2) begin : g_bad_buffers
    $error("in_system_flash_core supports one or two buffers");
  end
  if (AW > 24 || PAGE_BITS > 16 || BYTE_BITS < 1) begin : g_bad_geom
    $error("in_system_flash_core array must fit a 24-bit address");
  end
  if (2 * PAGE_BYTES + FIFO_DEPTH + 8 > COPY_LIMIT_CYCLES)
  begin : g_bad_time
    $error("in_system_flash_core page copy cannot meet its limit");
  end

  // page number field of a 24-bit address
  function automatic logic [15:0] page_of(input logic [23:0] a);
    page_of = 16'(a[AW-1:BYTE_BITS]);
  endfunction

  // pin synchroniser and edge history
  pins_type s1_q; // first stage, read only by s2_q
  pins_type s2_q; // settled pin levels
  logic sclk_prev_q; // settled clock one cycle back
  logic cs_prev_q; // settled select one cycle back

  // two flip-flops before a pin is read; reset to the pins' idle levels
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s1_q <= '{chip_select_low: 1'b1, sclk: 1'b1, mosi: 1'b0};
      s2_q <= '{chip_select_low: 1'b1, sclk: 1'b1, mosi: 1'b0};
      sclk_prev_q <= 1'b1;
      cs_prev_q <= 1'b1;
    end else begin
      s1_q <= '{chip_select_low: chip_select_low, sclk: sclk,
                mosi: mosi};
      s2_q <= s1_q;
      sclk_prev_q <= s2_q.sclk;
      cs_prev_q <= s2_q.chip_select_low;
    end
  end

  logic sclk_rise; // rising serial clock edge seen
  logic sclk_fall; // falling serial clock edge seen
  logic selected; // select is low
  logic cs_rise; // select just went high

  assign sclk_rise = s2_q.sclk & ~sclk_prev_q;
  assign sclk_fall = ~s2_q.sclk & sclk_prev_q;
  assign selected = ~s2_q.chip_select_low;
  assign cs_rise = s2_q.chip_select_low & ~cs_prev_q;

  // link state
  link_state_type state_q, state_d; // command decoder state
  logic [5:0] bitcnt_q, bitcnt_d; // command bits taken
  logic [31:0] shift_q, shift_d; // opcode and address shifter
  logic [AW-1:0] ptr_q, ptr_d; // read pointer into the array
  logic [7:0] out_q, out_d; // byte being shifted out
  logic [2:0] outbit_q, outbit_d; // bits left in out_q
  logic miso_q, miso_d; // serial data output
  copy_req_type req_q, req_d; // shifted copy request

  // copy engine state
  copy_state_type cstate_q, cstate_d; // engine state
  logic sel_q, sel_d; // target buffer
  logic [PAGE_BITS-1:0] page_q, page_d; // source page
  logic [BYTE_BITS:0] src_q, src_d; // bytes fetched from the array
  logic push_q, push_d; // array byte valid this cycle
  logic [BYTE_BITS-1:0] dst_q, dst_d; // next buffer byte to write
  logic [7:0] status_q, status_d; // status byte

  // shared array and fifo wiring
  logic [7:0] arr_rd_data; // array read data, one cycle late
  logic [AW-1:0] arr_rd_addr; // array read address
  logic fifo_in_ready; // fifo can take a byte
  logic fifo_out_valid; // fifo holds a byte
  logic fifo_out_ready; // buffer write port free
  logic [7:0] fifo_out_data; // byte leaving the fifo
  logic drain; // byte moves fifo to buffer
  logic [31:0] word; // shifter with the newest bit
  logic rd_sel; // buffer index of a user read

  assign word = {shift_q[30:0], s2_q.mosi};
  assign rd_sel = (BUFFERS == 2) ? buf_rd_sel : 1'b0;

  // command decoder and serial output, next values
  always_comb begin
    state_d = state_q;
    bitcnt_d = bitcnt_q;
    shift_d = shift_q;
    ptr_d = ptr_q;
    out_d = out_q;
    outbit_d = outbit_q;
    miso_d = miso_q;
    req_d = req_q;
    if (!selected) begin
      // deselect ends any command and parks the output
      state_d = ST_CMD;
      bitcnt_d = `CMD_CNT_ZERO;
      miso_d = `MISO_IDLE; // [R10]
      req_d = '0; // unarmed request is dropped here [R21]
    end else begin
      case (state_q)
        ST_CMD: begin
          // bits arrive on falls, taken on a rise once select settled
          if (sclk_rise && !cs_prev_q) begin
            shift_d = word; // [R2] [R3]
            bitcnt_d = bitcnt_q + 6'h01;
            if (bitcnt_q == `LAST_CMD_BIT) begin
              state_d = ST_DONE;
              if (word[31:24] == `OPC_RANDOM_READ &&
                  cstate_q == CP_IDLE) begin
                // start anywhere, no dummy cycles [R3] [R4]
                ptr_d = word[AW-1:0];
                outbit_d = 3'h0;
                state_d = ST_STREAM;
              end else if (word[31:24] == `OPC_COPY_BUF1) begin
                // arm buffer one copy, page field only [R13] [R14]
                req_d = '{valid: 1'b1, sel: 1'b0,
                          page: page_of(word[23:0])};
              end else if (word[31:24] == `OPC_COPY_BUF2 &&
                           BUFFERS == 2) begin
                // buffer two only where it exists [R13] [R19]
                req_d = '{valid: 1'b1, sel: 1'b1,
                          page: page_of(word[23:0])};
              end
            end
          end
        end
        ST_STREAM: begin
          // new bit every fall, mosi ignored [R4] [R5]
          if (sclk_fall) begin
            if (outbit_q == 3'h0) begin
              miso_d = arr_rd_data[7];
              out_d = {arr_rd_data[6:0], 1'b0};
              outbit_d = 3'h7;
              // contiguous, crosses pages and wraps freely [R8] [R9]
              ptr_d = ptr_q + 1'b1;
            end else begin
              miso_d = out_q[7];
              out_d = {out_q[6:0], 1'b0};
              outbit_d = outbit_q - 3'h1;
            end
          end
        end
        ST_DONE: begin
          // trailing bits ignored until deselect
        end
        default: begin
          state_d = ST_CMD;
        end
      endcase
    end
  end

  // command decoder registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q <= ST_CMD;
      bitcnt_q <= `CMD_CNT_ZERO;
      shift_q <= '0;
      ptr_q <= '0;
      out_q <= '0;
      outbit_q <= 3'h0;
      miso_q <= `MISO_IDLE;
      req_q <= '0;
    end else begin
      state_q <= state_d;
      bitcnt_q <= bitcnt_d;
      shift_q <= shift_d;
      ptr_q <= ptr_d;
      out_q <= out_d;
      outbit_q <= outbit_d;
      miso_q <= miso_d;
      req_q <= req_d;
    end
  end

  // a user read of the target buffer wins the write port
  assign fifo_out_ready = (cstate_q == CP_RUN) &
                          ~(buf_rd_en & rd_sel == sel_q);
  assign drain = fifo_out_valid & fifo_out_ready;
  // copy reads its page; stream reads only while idle [R11]
  assign arr_rd_addr = (cstate_q == CP_RUN) ?
                       {page_q, src_q[BYTE_BITS-1:0]} : ptr_q;

  // page copy engine, next values
  always_comb begin
    cstate_d = cstate_q;
    sel_d = sel_q;
    page_d = page_q;
    src_d = src_q;
    push_d = 1'b0;
    dst_d = dst_q;
    status_d = status_q;
    case (cstate_q)
      CP_IDLE: begin
        // full command and deselect start the copy [R15] [R21]
        if (cs_rise && req_q.valid) begin
          cstate_d = CP_RUN;
          sel_d = req_q.sel;
          page_d = PAGE_BITS'(req_q.page);
          src_d = '0;
          dst_d = '0;
          status_d = `STATUS_BUSY; // [R16]
        end
      end
      CP_RUN: begin
        // fetch one byte every other cycle, only when room remains
        if (!push_q && fifo_in_ready &&
            src_q < (BYTE_BITS+1)'(PAGE_BYTES)) begin
          push_d = 1'b1;
          src_d = src_q + 1'b1;
        end
        // every byte lands in the buffer [R12]
        if (drain) begin
          dst_d = dst_q + 1'b1;
          if (dst_q == BYTE_BITS'(PAGE_BYTES - 1)) begin
            cstate_d = CP_IDLE;
            status_d = `STATUS_RESET; // ready again [R16]
          end
        end
      end
      default: begin
        cstate_d = CP_IDLE;
        status_d = `STATUS_RESET;
      end
    endcase
  end

  // page copy engine registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cstate_q <= CP_IDLE;
      sel_q <= 1'b0;
      page_q <= '0;
      src_q <= '0;
      push_q <= 1'b0;
      dst_q <= '0;
      status_q <= `STATUS_RESET;
    end else begin
      cstate_q <= cstate_d;
      sel_q <= sel_d;
      page_q <= page_d;
      src_q <= src_d;
      push_q <= push_d;
      dst_q <= dst_d;
      status_q <= status_d;
    end
  end

  // sram page buffers; written only by the copy engine [R11]
  logic [7:0] buf_mem [BUFFERS][PAGE_BYTES];
  logic [7:0] buf_rd_q; // registered user read data

  // buffer write from the fifo and user read, served any time [R18]
  always_ff @(posedge ref_clk) begin
    if (drain) begin
      buf_mem[sel_q][dst_q] <= fifo_out_data; // [R12]
    end
    if (buf_rd_en) begin
      buf_rd_q <= buf_mem[rd_sel][buf_rd_addr];
    end
  end

  // the array is only read, never changed by a copy [R12]
  flash_array #(.AW(AW)) u_array (
    .ref_clk(ref_clk),
    .wr_en(flash_wr_en),
    .wr_addr(flash_wr_addr),
    .wr_data(flash_wr_data),
    .rd_addr(arr_rd_addr),
    .rd_data(arr_rd_data)
  );

  // bytes in flight between array and buffer
  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(push_q),
    .in_ready(fifo_in_ready),
    .in_data(arr_rd_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  assign miso = miso_q;
  assign status = status_q;
  assign buf_rd_data = buf_rd_q;
endmodule // in_system_flash_core

//--- tb/flash_core_asserts.sv
// concurrent checks on the serial pins and status of the flash core
// assumes it is bound to the core and sees only the core's ports
`timescale 1ns/100ps
module flash_core_asserts #(
  parameter int COPY_LIMIT_CYCLES = 600
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic chip_select_low,
  input wire logic sclk,
  input wire logic miso,
  input wire logic [7:0] status
);
  import flash_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [3:0] fall_age_q; // cycles since the serial clock last fell
  logic [3:0] rise_age_q; // cycles since select was last raised
  logic [5:0] bits_q; // serial clock rises seen in this frame
  logic [15:0] busy_q; // cycles that status has shown busy
  // counters that tie each pin change to its cause
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fall_age_q <= 4'hF;
      rise_age_q <= 4'hF;
      bits_q <= 6'h00;
      busy_q <= 16'h0000;
    end else begin
      fall_age_q <= $fell(sclk) ? 4'h0 :
        fall_age_q + {3'h0, fall_age_q != 4'hF};
      rise_age_q <= $rose(chip_select_low) ? 4'h0 :
        rise_age_q + {3'h0, rise_age_q != 4'hF};
      bits_q <= chip_select_low ? 6'h00 :
        bits_q + {5'h0, $rose(sclk) && bits_q != 6'h3F};
      busy_q <= status[7] ? 16'h0000 : busy_q + 16'h0001;
    end
  end
  sequence sel_idle; // select held high for a while
    chip_select_low [*6];
  endsequence
  sequence bit_lands; // a data bit appears inside a frame
    $changed(miso) && !chip_select_low;
  endsequence
  chk_idle_miso_high: assert property (sel_idle |-> miso)
    else $error("miso not high while deselected");
  chk_cmd_phase_quiet: assert property (
    !chip_select_low && bits_q < 6'h20 |-> miso)
    else $error("miso moved before the address was complete");
  chk_miso_after_fall: assert property (
    $changed(miso) |-> fall_age_q <= 4'h6 || rise_age_q <= 4'h6)
    else $error("miso changed without a clock fall");
  chk_bit_stands: assert property (
    bit_lands |=> $stable(miso) [*3])
    else $error("data bit did not stand");
  chk_status_spare: assert property (status[6:0] == 7'h00)
    else $error("status spare bits not zero");
  chk_reset_ready: assert property (
    $rose(rst_n) |-> status == 8'h80 && miso)
    else $error("not ready after reset");
  chk_busy_bounded: assert property (
    busy_q <= COPY_LIMIT_CYCLES)
    else $error("copy ran past its limit");
  chk_copy_on_deselect: assert property (
    $fell(status[7]) |-> chip_select_low && $past(chip_select_low, 2))
    else $error("copy began while selected");
endmodule // flash_core_asserts

//--- tb/serial_master_model.sv
// serial bus master standing in for the user logic on the far side
// assumes the core samples its pins; clock parks high between frames
`timescale 1ns/100ps
module serial_master_model (
  output logic chip_select_low,
  output logic sclk,
  output logic mosi,
  input wire logic miso
);
  localparam realtime HALF = 62.5; // 8 MHz, under the 33 MHz cap
  logic [7:0] rx_q [$]; // bytes read back in the last frame
  // pins idle: deselected, clock high
  initial begin
    chip_select_low = 1'b1;
    sclk = 1'b1;
    mosi = 1'b0;
  end
  // one frame: nbits of cmd msb first, then nrd bytes read back
  task automatic xfer(input logic [31:0] cmd, input int nbits,
                      input int nrd);
    logic [7:0] v;
    v = 8'h00;
    rx_q.delete();
    chip_select_low = 1'b0; // lowered while clock is high
    #HALF;
    // select stays low for the whole frame
    for (int i = 0; i < nbits + 8 * nrd; i++) begin
      sclk = 1'b0;
      // command bits msb first on falls, then moving noise
      mosi = (i < nbits) ? cmd[31-i] : ~mosi;
      #HALF;
      sclk = 1'b1;
      #HALF;
      if (i >= nbits) begin
        v = {v[6:0], miso};
        if ((i - nbits) % 8 == 7) rx_q.push_back(v);
      end
    end
    sclk = 1'b0;
    chip_select_low = 1'b1; // raised on a falling edge
    mosi = ~mosi;
    #HALF;
    sclk = 1'b1;
    #(4 * HALF);
  endtask
endmodule // serial_master_model

//--- tb/in_system_flash_core_tb.sv
// self-checking bench for the flash core: reads, copies, buffers
// assumes the core, its checker and the serial master model
`timescale 1ns/100ps
module in_system_flash_core_tb;
  import flash_pkg::*;
  localparam int LIM = 600; // shortened copy limit
  int seed = 32'haf3d; // fixed seed for repeatable stimulus
  int error_cnt = 0;
  int tests_run = 0;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic chip_select_low, sclk, mosi, miso;
  logic [7:0] status, buf_rd_data;
  logic flash_wr_en = 1'b0;
  logic [11:0] flash_wr_addr = 12'h000;
  logic [7:0] flash_wr_data = 8'h00;
  logic buf_rd_en = 1'b0;
  logic buf_rd_sel = 1'b0;
  logic [7:0] buf_rd_addr = 8'h00;
  logic [7:0] mem [4096]; // shadow of the flash array
  logic [7:0] bufm [2][256]; // expected sram buffer contents
  in_system_flash_core #(.COPY_LIMIT_CYCLES(LIM)) in_system_flash_core_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .chip_select_low(chip_select_low),
    .sclk(sclk), .mosi(mosi), .miso(miso), .status(status),
    .flash_wr_en(flash_wr_en), .flash_wr_addr(flash_wr_addr),
    .flash_wr_data(flash_wr_data), .buf_rd_en(buf_rd_en),
    .buf_rd_sel(buf_rd_sel), .buf_rd_addr(buf_rd_addr),
    .buf_rd_data(buf_rd_data));
  serial_master_model serial_master_model_inst (
    .chip_select_low(chip_select_low), .sclk(sclk), .mosi(mosi),
    .miso(miso));
  // byte comparison, counted
  task automatic chk8(input string nm, input logic [7:0] exp,
                      input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // verdict and end of run
  task automatic conclude;
    if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // whole buffer read back to back through the user port
  task automatic rd_buf(input logic s);
    for (int i = 0; i <= 256; i++) begin
      @(negedge ref_clk);
      if (i > 0) chk8("buf_rd_data", bufm[s][i-1], buf_rd_data);
      buf_rd_en = (i < 256);
      buf_rd_sel = s;
      buf_rd_addr = i[7:0];
    end
  endtask
  // random read frame and byte by byte comparison
  task automatic rd_flash(input logic [11:0] a, input int n);
    logic [7:0] got;
    @(negedge ref_clk);
    #1; // keeps serial pin changes off the core's clock edges
    serial_master_model_inst.xfer({8'h03, 12'h000, a}, 32, n);
    for (int k = 0; k < n; k++) begin
      got = serial_master_model_inst.rx_q[k];
      chk8("miso byte", mem[12'(a + k)], got);
    end
  endtask
  // frame whose read must be refused: miso has to stay high
  task automatic rd_none(input logic [7:0] op);
    logic [7:0] got;
    @(negedge ref_clk);
    #1; // keeps serial pin changes off the core's clock edges
    serial_master_model_inst.xfer({op, 24'h000000}, 32, 1);
    got = serial_master_model_inst.rx_q[0];
    chk8("refused miso", 8'hFF, got);
  endtask
  // page copy frame, poll, then buffer check
  task automatic copy(input logic [7:0] op, input logic [3:0] pg,
                      input int nbits, input bit ovl);
    logic s;
    logic [31:0] cmd;
    s = (op == 8'h55);
    cmd = {op, 12'h000, pg, 8'($random(seed))}; // offset byte is noise
    @(negedge ref_clk);
    #1; // keeps serial pin changes off the core's clock edges
    serial_master_model_inst.xfer(cmd, nbits, 0);
    @(negedge ref_clk);
    chk8("status", (nbits == 32) ? 8'h00 : 8'h80, status);
    if (ovl) begin
      // other buffer readable and random read refused while copying
      fork
        rd_buf(~s);
        rd_none(8'h03);
      join
    end
    for (int n = 0; n < LIM + 50 && status !== 8'h80; n++)
      @(negedge ref_clk); // poll ready before reading
    chk8("status", 8'h80, status);
    if (nbits == 32)
      for (int i = 0; i < 256; i++) bufm[s][i] = mem[{pg, 8'(i)}];
    rd_buf(s);
  endtask
  // core clock, 100 MHz
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // cuts a hang short
  initial begin
    #500000;
    error_cnt++;
    conclude();
  end
  // main sequence
  initial begin
    repeat (8) @(negedge ref_clk);
    rst_n = 1'b1;
    for (int a = 0; a < 4096; a++) begin
      @(negedge ref_clk);
      flash_wr_en = 1'b1;
      flash_wr_addr = a[11:0];
      flash_wr_data = 8'($random(seed));
      mem[a] = flash_wr_data;
    end
    @(negedge ref_clk);
    flash_wr_en = 1'b0;
    rd_flash(12'h1FD, 5);
    rd_flash(12'hFFE, 4);
    repeat (3) rd_flash(12'($random(seed)), 2);
    rd_none(8'hA5);
    copy(8'h53, 4'h2, 32, 1'b0);
    copy(8'h55, 4'h9, 32, 1'b0);
    copy(8'h53, 4'hF, 32, 1'b1);
    rd_flash(12'hF00, 3);
    rd_buf(1'b0);
    rd_buf(1'b1);
    copy(8'h55, 4'h4, 20, 1'b0);
    conclude();
  end
endmodule // in_system_flash_core_tb
bind in_system_flash_core flash_core_asserts #(
  .COPY_LIMIT_CYCLES(COPY_LIMIT_CYCLES)) flash_core_asserts_inst (
  .ref_clk(ref_clk), .rst_n(rst_n), .chip_select_low(chip_select_low),
  .sclk(sclk), .miso(miso), .status(status));
